// File: rtl/pom_monitor.sv
// Overview of operation
// - the remote fault bit is taken from its fixed overhead position in every frame.
// - a remote fault bit of one means the far receiver is in defect, zero means normal.
// - the remote fault defect is a held state built from the extracted bit.
// - remote fault cause is defect and monitored and its report enable.
// - a frame is an errored block when any alignment word bit is wrong.
// - near defect second from trail fail or equipment defect, far from remote fault.
// - the errored block count is the sum of errored blocks per interval; a block flagged in the tick cycle is counted in neither interval.
// - performance outputs exist only while performance monitoring is enabled.
//
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
module pom_monitor
    import pom_pkg::*;
#(
    parameter int PM_CYC = PM_INTERVAL_CYC,
    parameter int DEF_FRAMES = RF_FRAMES
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // tapped path stream
    input wire logic i_path_ck,
    input wire logic i_path_d,
    input wire logic i_path_fs,
    input wire logic i_upstream_fail_in,
    // avalon-mm slave
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // defect and performance outputs
    output logic o_trail_fail_out,
    output logic o_remote_fault_cause,
    output logic o_upstream_fail_cause,
    output logic o_near_defect_second,
    output logic o_far_defect_second,
    output logic o_irq
);
    pom_link_if lk ();

    pom_frame_track u_frm (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .lk(lk)
    );

    // two-stage synchronisers for the asynchronous tap
    logic [3:0] sy1_r;
    logic [3:0] sy2_r;
    logic ck_d_r;
    logic ssf;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge i_clk_sys) begin
                if (!i_rst_n) begin
                    sy1_r[gi] <= 1'b0;
                    sy2_r[gi] <= 1'b0;
                end else begin
                    sy1_r[gi] <= (gi == 0) ? i_path_ck : (gi == 1) ? i_path_d :
                                 (gi == 2) ? i_path_fs : i_upstream_fail_in;
                    sy2_r[gi] <= sy1_r[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ck_d_r <= 1'b0;
        end else begin
            ck_d_r <= sy2_r[0];
        end
    end

    // data and frame start share the synchroniser delay with the clock,
    // so they are taken at the synchronised rising edge
    assign lk.bit_en = sy2_r[0] & ~ck_d_r;
    assign lk.bit_d = sy2_r[1];
    assign lk.bit_fs = sy2_r[2];
    assign ssf = sy2_r[3];

    // register file
    logic [CTL_W-1:0] ctrl_r;
    logic [IRQ_W-1:0] ist_r;
    logic [IRQ_W-1:0] imask_r;
    logic [IRQ_W-1:0] ev;
    logic wr_acc;
    logic rd_acc;
    logic mon;
    logic pm_en;

    assign wr_acc = i_avs_write && !o_avs_waitrequest;
    assign rd_acc = i_avs_read && !o_avs_waitrequest;
    assign mon = ctrl_r[CTL_MON];
    assign pm_en = ctrl_r[CTL_PM_EN];

    // one wait cycle per access: request seen, then answer
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_avs_waitrequest <= 1'b1;
        end else if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
            o_avs_waitrequest <= 1'b0;
        end else begin
            o_avs_waitrequest <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ctrl_r <= CTRL_RST;
            imask_r <= IMASK_RST;
        end else if (wr_acc && i_avs_byteenable[0]) begin
            if (i_avs_address == ADR_CTRL) begin
                ctrl_r <= i_avs_writedata[CTL_W-1:0];
            end
            if (i_avs_address == ADR_IMASK) begin
                imask_r <= i_avs_writedata[IRQ_W-1:0];
            end
        end
    end

    // remote fault defect
    logic rfd_r;
    logic [3:0] rf_run_r;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            rfd_r <= 1'b0;
            rf_run_r <= 4'h0;
        end else if (lk.frm_end) begin
            // a one means the far receiver is in defect
            if (lk.rf_bit != rfd_r) begin
                if (rf_run_r == 4'(DEF_FRAMES - 1)) begin
                    rfd_r <= lk.rf_bit;
                    rf_run_r <= 4'h0;
                end else begin
                    rf_run_r <= rf_run_r + 4'h1;
                end
            end else begin
                rf_run_r <= 4'h0;
            end
        end
    end

    // consequent action and defect correlations
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_trail_fail_out <= 1'b0;
            o_remote_fault_cause <= 1'b0;
            o_upstream_fail_cause <= 1'b0;
        end else begin
            o_trail_fail_out <= ssf;
            o_remote_fault_cause <= rfd_r && mon && ctrl_r[CTL_RF_REP];
            o_upstream_fail_cause <= ssf && mon && ctrl_r[CTL_UF_REP];
        end
    end

    // performance monitoring
    logic [31:0] cyc_r;
    logic tick;
    logic [NEBC_W-1:0] nebc_acc_r;
    logic [NEBC_W-1:0] nebc_r;
    logic nds_acc_r;
    logic fds_acc_r;
    logic near_def;

    assign tick = (cyc_r == 32'(PM_CYC - 1));
    // trail fail action is the synchronised upstream fail
    assign near_def = ssf || ctrl_r[CTL_EQ_DEF];

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cyc_r <= 32'h0000_0000;
        end else begin
            cyc_r <= tick ? 32'h0000_0000 : cyc_r + 32'h0000_0001;
        end
    end

    // counter saturates rather than wrap, so a bad interval never reads low
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || !pm_en) begin
            nebc_acc_r <= '0;
            nebc_r <= '0;
        end else if (tick) begin
            nebc_r <= nebc_acc_r;
            nebc_acc_r <= '0;
        end else if (lk.blk_err && nebc_acc_r != '1) begin
            nebc_acc_r <= nebc_acc_r + 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || !pm_en) begin
            nds_acc_r <= 1'b0;
            fds_acc_r <= 1'b0;
            o_near_defect_second <= 1'b0;
            o_far_defect_second <= 1'b0;
        end else if (tick) begin
            o_near_defect_second <= nds_acc_r || near_def;
            o_far_defect_second <= fds_acc_r || rfd_r;
            nds_acc_r <= 1'b0;
            fds_acc_r <= 1'b0;
        end else begin
            nds_acc_r <= nds_acc_r || near_def;
            fds_acc_r <= fds_acc_r || rfd_r;
        end
    end

    // interrupts: events win over a simultaneous write-one clear
    logic ssf_d_r;
    logic rfd_d_r;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ssf_d_r <= 1'b0;
            rfd_d_r <= 1'b0;
        end else begin
            ssf_d_r <= ssf;
            rfd_d_r <= rfd_r;
        end
    end

    always_comb begin
        ev = '0;
        ev[IRQ_RF_CHG] = rfd_r ^ rfd_d_r;
        ev[IRQ_UF_RISE] = ssf && !ssf_d_r;
        ev[IRQ_BLK_ERR] = lk.blk_err;
        ev[IRQ_TICK] = tick && pm_en;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ist_r <= '0;
        end else if (wr_acc && i_avs_byteenable[0] && i_avs_address == ADR_IST) begin
            ist_r <= (ist_r & ~i_avs_writedata[IRQ_W-1:0]) | ev;
        end else begin
            ist_r <= ist_r | ev;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(ist_r & imask_r);
        end
    end

    // read path; unmapped offsets read zero
    logic [31:0] rdata;

    always_comb begin
        rdata = 32'h0000_0000;
        case (i_avs_address)
            ADR_CTRL: rdata[CTL_W-1:0] = ctrl_r;
            ADR_STAT: rdata[5:0] = {o_far_defect_second, o_near_defect_second,
                                    ssf, o_upstream_fail_cause,
                                    o_remote_fault_cause, rfd_r};
            ADR_IST: rdata[IRQ_W-1:0] = ist_r;
            ADR_IMASK: rdata[IRQ_W-1:0] = imask_r;
            ADR_NEBC: rdata[NEBC_W-1:0] = nebc_r;
            ADR_NEBC_RUN: rdata[NEBC_W-1:0] = nebc_acc_r;
            default: rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (i_avs_read && o_avs_waitrequest) begin
            o_avs_readdata <= rdata;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    property p_rf_enter;
        $rose(rfd_r) |-> $past(lk.frm_end && lk.rf_bit);
    endproperty
    a_rf_enter: assert property (p_rf_enter)
        else $error("defect entered without a remote fault bit of one");

    property p_rf_hold;
        !lk.frm_end |=> $stable(rfd_r);
    endproperty
    a_rf_hold: assert property (p_rf_hold)
        else $error("remote fault defect moved between frames");

    property p_rfc;
        (rfd_r && mon && ctrl_r[CTL_RF_REP]) ##1 $stable(rfd_r && mon && ctrl_r[CTL_RF_REP])
            |-> o_remote_fault_cause;
    endproperty
    a_rfc: assert property (p_rfc)
        else $error("remote fault cause missing");

    property p_ufc;
        o_upstream_fail_cause |-> $past(ssf) && $past(mon) && $past(ctrl_r[CTL_UF_REP]);
    endproperty
    a_ufc: assert property (p_ufc)
        else $error("upstream fail cause without all conditions");

    property p_tsf;
        $rose(i_upstream_fail_in) ##1 i_upstream_fail_in [*3] |=> o_trail_fail_out;
    endproperty
    a_tsf: assert property (p_tsf)
        else $error("trail fail not following upstream fail");

    property p_mon_off;
        !mon |=> !o_remote_fault_cause && !o_upstream_fail_cause;
    endproperty
    a_mon_off: assert property (p_mon_off)
        else $error("cause raised while not monitored");

    property p_nebc_sum;
        (pm_en && !tick && lk.blk_err && nebc_acc_r != '1) ##1 pm_en
            |-> nebc_acc_r == $past(nebc_acc_r) + 1'b1;
    endproperty
    a_nebc_sum: assert property (p_nebc_sum)
        else $error("errored block not counted");

    property p_far_second;
        (pm_en && tick && rfd_r) ##1 pm_en |-> o_far_defect_second;
    endproperty
    a_far_second: assert property (p_far_second)
        else $error("far defect second not flagged");

    property p_pm_off;
        !pm_en |=> nebc_r == '0 && !o_near_defect_second && !o_far_defect_second;
    endproperty
    a_pm_off: assert property (p_pm_off)
        else $error("performance output active while disabled");

    property p_wait_one;
        ((i_avs_read || i_avs_write) && o_avs_waitrequest) |=> !o_avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("slave did not answer after one wait cycle");

    c_rf_enter: cover property ($rose(rfd_r));
    c_cause: cover property (o_remote_fault_cause);
    c_tick_err: cover property (tick && nebc_acc_r != '0);
    c_irq: cover property ($rose(o_irq));
endmodule : pom_monitor

// File: rtl/pom_pkg.sv
package pom_pkg;
    // system clock and frame geometry
    localparam int CLK_HZ = 40_000_000;
    localparam int FRAME_BITS = 848;
    localparam int FAW_LEN = 10;
    localparam logic [9:0] FAW_VAL = 10'h3d0;
    // remote fault bit position, counted from the frame start bit (0)
    localparam int RF_POS = 10;
    // consecutive frames needed to enter or leave the remote fault defect
    localparam int RF_FRAMES = 5;
    // performance counting interval
    localparam int PM_INTERVAL_S = 1;
    localparam int PM_INTERVAL_CYC = PM_INTERVAL_S * CLK_HZ;
    localparam int NEBC_W = 16;

    // register byte offsets
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STAT = 8'h04;
    localparam logic [7:0] ADR_IST = 8'h08;
    localparam logic [7:0] ADR_IMASK = 8'h0c;
    localparam logic [7:0] ADR_NEBC = 8'h10;
    localparam logic [7:0] ADR_NEBC_RUN = 8'h14;

    // control fields
    localparam int CTL_MON = 0;
    localparam int CTL_RF_REP = 1;
    localparam int CTL_UF_REP = 2;
    localparam int CTL_PM_EN = 3;
    localparam int CTL_EQ_DEF = 4;
    localparam int CTL_W = 5;
    localparam logic [4:0] CTRL_RST = 5'h0f;

    // interrupt status and mask fields
    localparam int IRQ_RF_CHG = 0;
    localparam int IRQ_UF_RISE = 1;
    localparam int IRQ_BLK_ERR = 2;
    localparam int IRQ_TICK = 3;
    localparam int IRQ_W = 4;
    localparam logic [3:0] IMASK_RST = 4'h0;

    typedef enum logic {
        FRM_WAIT = 1'b0,
        FRM_RUN = 1'b1
    } pom_frm_t;
endpackage : pom_pkg

// File: rtl/pom_link_if.sv
interface pom_link_if;
    logic bit_en;
    logic bit_d;
    logic bit_fs;
    logic frm_end;
    logic rf_bit;
    logic blk_err;
    modport mon (
        output bit_en, bit_d, bit_fs,
        input frm_end, rf_bit, blk_err
    );
    modport frm (
        input bit_en, bit_d, bit_fs,
        output frm_end, rf_bit, blk_err
    );
endinterface : pom_link_if

// File: rtl/pom_frame_track.sv
module pom_frame_track
    import pom_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    pom_link_if.frm lk
);
    pom_frm_t st_r;
    logic [9:0] cnt_r;
    logic [FAW_LEN-2:0] sh_r;
    logic err_r;
    logic rf_r;
    logic [9:0] pos;
    logic last;

    assign pos = lk.bit_fs ? 10'h000 : cnt_r;
    assign last = (pos == 10'(FRAME_BITS - 1));

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            st_r <= FRM_WAIT;
            cnt_r <= 10'h000;
            sh_r <= '0;
            err_r <= 1'b0;
            rf_r <= 1'b0;
            lk.frm_end <= 1'b0;
            lk.blk_err <= 1'b0;
            lk.rf_bit <= 1'b0;
        end else begin
            lk.frm_end <= 1'b0;
            lk.blk_err <= 1'b0;
            if (lk.bit_en) begin
                if (lk.bit_fs) begin
                    st_r <= FRM_RUN;
                end
                cnt_r <= last ? 10'h000 : pos + 10'h001;
                sh_r <= {sh_r[FAW_LEN-3:0], lk.bit_d};
                // any single wrong alignment bit spoils the block
                if (pos == 10'(FAW_LEN - 1)) begin
                    err_r <= ({sh_r, lk.bit_d} != FAW_VAL);
                end
                if (pos == 10'(RF_POS)) begin
                    rf_r <= lk.bit_d;
                end
                // no report until a frame start has been seen
                if (last && (st_r == FRM_RUN || lk.bit_fs)) begin
                    lk.frm_end <= 1'b1;
                    lk.blk_err <= err_r;
                    lk.rf_bit <= rf_r;
                end
            end
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    property p_blk_err_in_frame;
        lk.blk_err |-> lk.frm_end;
    endproperty
    a_blk_err_in_frame: assert property (p_blk_err_in_frame)
        else $error("errored block flagged outside a frame end");

    property p_rf_taken;
        (lk.bit_en && pos == 10'(RF_POS)) |=> rf_r == $past(lk.bit_d);
    endproperty
    a_rf_taken: assert property (p_rf_taken)
        else $error("remote fault bit not taken at its position");

    property p_frame_gap;
        lk.frm_end |=> !lk.frm_end [*8];
    endproperty
    a_frame_gap: assert property (p_frame_gap)
        else $error("frame ends too close together");

    c_blk_err: cover property (lk.frm_end && lk.blk_err);
endmodule : pom_frame_track

// File: tb/pom_path_model.sv
module pom_path_model
    import pom_pkg::*;
(
    // tapped stream
    output logic o_path_ck,
    output logic o_path_d,
    output logic o_path_fs
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_path_ck = 1'b0;
        o_path_d = 1'b0;
        o_path_fs = 1'b0;
    end

    // data moves on the falling edge; the clock stands still between frames
    // called on a system clock edge and 200 ns is a whole number of system
    // periods, so every change is non-blocking to stay clear of the sampling race
    task automatic send_frame(input logic rf, input logic [9:0] faw);
        for (int i = 0; i < FRAME_BITS; i++) begin
            if (i < FAW_LEN) begin
                o_path_d <= faw[FAW_LEN - 1 - i];
            end else if (i == RF_POS) begin
                o_path_d <= rf;
            end else begin
                o_path_d <= i[0] ^ i[2];
            end
            o_path_fs <= (i == 0);
            #100 o_path_ck <= 1'b1;
            #100 o_path_ck <= 1'b0;
        end
        // flip the idle data so a stale bit is never mistaken for a held one
        o_path_d <= ~o_path_d;
        o_path_fs <= 1'b0;
    endtask : send_frame
endmodule : pom_path_model

// File: tb/tb_top.sv
module tb_top
    import pom_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    // short interval that still holds one whole frame
    localparam int TB_PM = 8000;
    localparam int TB_DEF = 2;

    logic clk, rst_n, path_ck, path_d, path_fs, uf;
    logic [7:0] avs_address;
    logic avs_read, avs_write, waitreq;
    logic [31:0] avs_writedata, rdata;
    logic [3:0] avs_be;
    logic trail, rfc, ufc, nds, fds, irq;
    int miscompares = 0;
    int checked = 0;

    pom_path_model pom_path_model_inst (
        .o_path_ck(path_ck),
        .o_path_d(path_d),
        .o_path_fs(path_fs)
    );

    pom_monitor #(.PM_CYC(TB_PM), .DEF_FRAMES(TB_DEF)) pom_monitor_inst (
        .i_clk_sys(clk),
        .i_rst_n(rst_n),
        .i_path_ck(path_ck),
        .i_path_d(path_d),
        .i_path_fs(path_fs),
        .i_upstream_fail_in(uf),
        .i_avs_address(avs_address),
        .i_avs_read(avs_read),
        .i_avs_write(avs_write),
        .i_avs_writedata(avs_writedata),
        .i_avs_byteenable(avs_be),
        .o_avs_readdata(rdata),
        .o_avs_waitrequest(waitreq),
        .o_trail_fail_out(trail),
        .o_remote_fault_cause(rfc),
        .o_upstream_fail_cause(ufc),
        .o_near_defect_second(nds),
        .o_far_defect_second(fds),
        .o_irq(irq)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // request held until waitrequest is sampled low, released at that edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        // no cycle count is assumed; only the watchdog ends a stuck wait
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        q = rdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(name, q & m, exp);
    endtask : rd_chk

    task automatic ctl_chk(input string name, input logic [31:0] c, input logic sel_rf,
                           input logic exp);
        wr(ADR_CTRL, c);
        cyc(2);
        chk(name, sel_rf ? rfc : ufc, {31'h0, exp});
    endtask : ctl_chk

    // lines the test up with the start of a counting interval
    task automatic wait_tick();
        logic [31:0] q;
        wr(ADR_IST, 32'hf);
        q = 32'h0;
        for (int i = 0; i < 4000 && q[IRQ_TICK] !== 1'b1; i++) begin
            bus(1'b0, ADR_IST, 32'h0, q);
        end
        chk("interval tick", {31'h0, q[IRQ_TICK]}, 32'h1);
    endtask : wait_tick

    task automatic frame(input logic rf, input logic [9:0] faw);
        pom_path_model_inst.send_frame(rf, faw);
        cyc(10);
    endtask : frame

    initial begin
        rst_n = 1'b0;
        uf = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_be = 4'hf;
        cyc(3);
        rst_n <= 1'b1;
        cyc(2);
        chk("waitrequest idle", waitreq, 32'h1);
        chk("outputs", {trail, rfc, ufc, nds, fds, irq}, 32'h0);
        rd_chk("ctrl reset", ADR_CTRL, 32'h1f, {27'h0, CTRL_RST});
        rd_chk("imask reset", ADR_IMASK, 32'hf, {28'h0, IMASK_RST});
        rd_chk("stat reset", ADR_STAT, 32'h3f, 32'h0);
        wr(8'h20, 32'hffffffff);
        rd_chk("unmapped", 8'h20, 32'hffffffff, 32'h0);
        avs_be <= 4'h0;
        wr(ADR_CTRL, 32'h0);
        avs_be <= 4'hf;
        rd_chk("ctrl lane off", ADR_CTRL, 32'h1f, 32'h0f);
        uf <= 1'b1;
        cyc(10);
        chk("trail fail", trail, 32'h1);
        chk("uf cause", ufc, 32'h1);
        rd_chk("stat uf", ADR_STAT, 32'hc, 32'hc);
        rd_chk("ist uf rise", ADR_IST, 32'h2, 32'h2);
        chk("irq masked", irq, 32'h0);
        wr(ADR_IMASK, 32'h2);
        cyc(2);
        chk("irq on", irq, 32'h1);
        wr(ADR_IST, 32'h2);
        cyc(2);
        chk("irq cleared", irq, 32'h0);
        wr(ADR_IMASK, 32'h0);
        cyc(TB_PM + 20);
        chk("near second uf", nds, 32'h1);
        ctl_chk("uf cause unreported", 32'h0b, 1'b0, 1'b0);
        chk("trail fail kept", trail, 32'h1);
        ctl_chk("uf cause unmonitored", 32'h0e, 1'b0, 1'b0);
        ctl_chk("uf cause back", 32'h0f, 1'b0, 1'b1);
        uf <= 1'b0;
        cyc(10);
        chk("trail fail off", trail, 32'h0);
        chk("uf cause off", ufc, 32'h0);
        wr(ADR_CTRL, 32'h17);
        cyc(TB_PM + 20);
        chk("near second pm off", nds, 32'h0);
        wr(ADR_CTRL, 32'h1f);
        cyc(TB_PM + 20);
        chk("near second equipment", nds, 32'h1);
        wr(ADR_CTRL, 32'h0f);
        wait_tick();
        frame(1'b0, FAW_VAL ^ 10'h200);
        rd_chk("running count", ADR_NEBC_RUN, 32'hffff, 32'h1);
        rd_chk("ist block err", ADR_IST, 32'h4, 32'h4);
        wait_tick();
        rd_chk("interval count", ADR_NEBC, 32'hffff, 32'h1);
        wr(ADR_IST, 32'hf);
        frame(1'b1, FAW_VAL);
        rd_chk("ist good frame", ADR_IST, 32'h4, 32'h0);
        rd_chk("defect one frame", ADR_STAT, 32'h1, 32'h0);
        frame(1'b1, FAW_VAL);
        rd_chk("defect on", ADR_STAT, 32'h3, 32'h3);
        chk("rf cause", rfc, 32'h1);
        rd_chk("ist defect change", ADR_IST, 32'h1, 32'h1);
        ctl_chk("rf cause unreported", 32'h0d, 1'b1, 1'b0);
        ctl_chk("rf cause unmonitored", 32'h0e, 1'b1, 1'b0);
        ctl_chk("rf cause back", 32'h0f, 1'b1, 1'b1);
        cyc(TB_PM + 20);
        chk("far second", fds, 32'h1);
        frame(1'b0, FAW_VAL);
        rd_chk("defect held", ADR_STAT, 32'h1, 32'h1);
        frame(1'b0, FAW_VAL);
        rd_chk("defect off", ADR_STAT, 32'h3, 32'h0);
        chk("rf cause off", rfc, 32'h0);
        end_sim();
    end

    initial begin
        cyc(95000);
        miscompares++;
        end_sim();
    end
endmodule : tb_top
